// >>> inc/acs_pkg.sv
// constants and helpers shared by the conversion sequencer files
`default_nettype none
package acs_pkg;

  // clock rate and the cycle counts derived from it
  localparam int CLK_MHZ   = 125;
  localparam int RC_TAD_NS = 2500;
  localparam logic [8:0] RC_DIV = 9'(RC_TAD_NS * CLK_MHZ / 1000);

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PINCFG = 8'h04;
  localparam logic [7:0] OFS_ACQCLK = 8'h08;
  localparam logic [7:0] OFS_RES_LO = 8'h0c;
  localparam logic [7:0] OFS_RES_HI = 8'h10;
  localparam logic [7:0] OFS_IRQ    = 8'h14;

  // field positions
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_ON_BIT = 1;
  localparam int CTRL_CH_LSB = 2;
  localparam int CLK_SEL_LSB = 0;
  localparam int ACQ_SEL_LSB = 3;
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_EN_BIT   = 1;

  // values after reset, and the manual acquisition code
  localparam logic [2:0] ACQ_SEL_RST = 3'h0;
  localparam logic [2:0] CLK_SEL_RST = 3'h0;
  localparam logic [2:0] ACQ_MANUAL  = 3'h0;

  // conversion geometry, counted in conversion-clock periods
  localparam int RES_W     = 12;
  localparam int CONV_TADS = 13;
  localparam logic [4:0] CONV_LAST = 5'h0c;
  localparam logic [4:0] WAIT_LAST = 5'h01;
  localparam logic [RES_W-1:0] SAR_MSB = 12'h800;

  // acquisition periods per selector code
  function automatic logic [4:0] acs_acq_tads(input logic [2:0] sel);
    case (sel)
      3'h1: return 5'h02;
      3'h2: return 5'h04;
      3'h3: return 5'h06;
      3'h4: return 5'h08;
      3'h5: return 5'h0c;
      3'h6: return 5'h10;
      3'h7: return 5'h14;
      default: return 5'h00;
    endcase
  endfunction

  // oscillator periods per conversion-clock period
  function automatic logic [8:0] acs_div(input logic [2:0] sel);
    case (sel)
      3'h0: return 9'h002;
      3'h4: return 9'h004;
      3'h1: return 9'h008;
      3'h5: return 9'h010;
      3'h2: return 9'h020;
      3'h6: return 9'h040;
      default: return RC_DIV;
    endcase
  endfunction

endpackage
`default_nettype wire

// >>> inc/acs_tad_if.sv
// link between the sequencer and its conversion-clock divider
`timescale 1ns/1ps
`default_nettype none
interface acs_tad_if;
  logic       run;
  logic [2:0] clk_sel;
  logic       tick;
  modport seq (output run, output clk_sel, input tick);
  modport gen (input run, input clk_sel, output tick);
endinterface
`default_nettype wire

// >>> design/acs_tad_gen.sv
// conversion-clock tick divider
`timescale 1ns/1ps
`default_nettype none
module acs_tad_gen
  import acs_pkg::*;
(
  // clock, reset, enable
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // sequencer side
  acs_tad_if.gen    tad
);

  typedef struct packed {
    logic [8:0] cnt;
    logic       tick;
  } acs_gen_s;

  acs_gen_s   st_q;
  acs_gen_s   st_d;
  logic [8:0] gap_q;

  // restarted on run so each period starts aligned to the start event
  // divider decode
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (!tad.run) begin
      st_d.cnt = '0;
    end else if (st_q.cnt == acs_div(tad.clk_sel) - 9'h001) begin
      st_d.cnt = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 9'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign tad.tick = st_q.tick;

  // cycles since run rose or since the last tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= '0;
    end else if (ce) begin
      // starts one behind: the first period opens a cycle after run rises
      gap_q <= (!tad.run) ? 9'h1ff :
               (st_q.tick ? 9'h000 : gap_q + 9'h001);
    end
  end

  tick_spacing_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_q.tick && tad.run && $stable(tad.clk_sel))
      |-> (gap_q == acs_div(tad.clk_sel) - 9'h001 || $past(!tad.run)))
    else $error("tick spacing differs from selected division");

endmodule
`default_nettype wire

// >>> design/acs_sequencer.sv
// conversion sequencer: apb registers, acquisition timing, sar control
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer
  import acs_pkg::*;
(
  // clock, reset, enable
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  // apb slave
  input  wire logic [7:0]       paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  // analog front end
  input  wire logic             cmp_in,
  output logic                  sample_connect,
  output logic                  array_discharge,
  output logic [3:0]            chan_sel,
  output logic [RES_W-1:0]      dac_code,
  output logic [7:0]            pin_cfg,
  // interrupt request
  output logic                  conv_irq_req
);

  typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV, ST_WAIT} acs_state_e;

  typedef struct packed {
    logic             cmp_cap;
    logic             go;
    logic             on;
    logic [3:0]       chan;
    logic [7:0]       pincfg;
    logic [2:0]       acq_sel;
    logic [2:0]       clk_sel;
    logic             flag;
    logic             irq_en;
    acs_state_e       fsm;
    logic [4:0]       tad_cnt;
    logic [RES_W-1:0] sar;
    logic             done;
    logic [31:0]      prdata;
    logic             pslverr;
  } acs_ctl_s;

  typedef struct packed {
    acs_ctl_s         c;
    logic [RES_W-1:0] result;
  } acs_st_s;

  acs_st_s          st_q;
  acs_st_s          st_d;
  logic [RES_W-1:0] sar_nx;
  int               bidx;
  logic             cmp;
  logic             setup;
  logic             wr;
  logic             ctrl_wr;
  logic             res_wr;
  logic [4:0]       acq_ticks_q;
  logic [4:0]       conv_ticks_q;

  acs_tad_if tad ();

  acs_tad_gen u_tad_gen (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .tad     (tad)
  );

  // one capture stage only: at divide-by-two a trial code has two cycles
  assign cmp     = st_q.c.cmp_cap;
  assign setup   = psel && !penable;
  assign wr      = psel && penable && pwrite;
  assign ctrl_wr = wr && (paddr == OFS_CTRL);
  assign res_wr  = wr && (paddr == OFS_RES_LO || paddr == OFS_RES_HI);

  // divider runs only while a sequence is in flight
  assign tad.run     = (st_q.c.fsm != ST_IDLE);
  assign tad.clk_sel = st_q.c.clk_sel;

  always_comb begin
    st_d = st_q;
    sar_nx = st_q.c.sar;
    bidx = 0;
    st_d.c.done = 1'b0;
    st_d.c.cmp_cap = cmp_in;
    case (st_q.c.fsm)
      ST_IDLE: begin
        if (st_q.c.go && st_q.c.on) begin
          st_d.c.tad_cnt = '0;
          st_d.c.sar = '0;
          if (st_q.c.acq_sel == ACQ_MANUAL) begin
            st_d.c.fsm = ST_CONV;
          end else begin
            st_d.c.fsm = ST_ACQ;
          end
        end
      end
      ST_ACQ: begin
        if (!st_q.c.go) begin
          st_d.c.fsm = ST_WAIT;
          st_d.c.tad_cnt = '0;
        end else if (tad.tick) begin
          st_d.c.tad_cnt = st_q.c.tad_cnt + 5'h01;
          if (st_d.c.tad_cnt == acs_acq_tads(st_q.c.acq_sel)) begin
            st_d.c.fsm = ST_CONV;
            st_d.c.tad_cnt = '0;
          end
        end
      end
      ST_CONV: begin
        if (!st_q.c.go) begin
          st_d.c.fsm = ST_WAIT;
          st_d.c.tad_cnt = '0;
        end else if (tad.tick) begin
          if (st_q.c.tad_cnt == 5'h00) begin
            sar_nx = SAR_MSB;
          end else begin
            bidx = RES_W - int'(st_q.c.tad_cnt);
            if (!cmp) begin
              sar_nx[bidx] = 1'b0;
            end
            if (bidx > 0) begin
              sar_nx[bidx-1] = 1'b1;
            end
          end
          st_d.c.sar = sar_nx;
          st_d.c.tad_cnt = st_q.c.tad_cnt + 5'h01;
          if (st_q.c.tad_cnt == CONV_LAST) begin
            st_d.c.fsm = ST_WAIT;
            st_d.c.tad_cnt = '0;
            st_d.c.go = 1'b0;
            st_d.c.done = 1'b1;
            st_d.result = sar_nx;
          end
        end
      end
      ST_WAIT: begin
        if (tad.tick) begin
          st_d.c.tad_cnt = st_q.c.tad_cnt + 5'h01;
          if (st_q.c.tad_cnt == WAIT_LAST) begin
            st_d.c.fsm = ST_IDLE;
            st_d.c.tad_cnt = '0;
          end
        end
      end
      default: begin
        st_d.c.fsm = ST_IDLE;
      end
    endcase
    // read data is latched in the setup cycle, pready is always high
    if (setup) begin
      st_d.c.prdata = '0;
      st_d.c.pslverr = 1'b0;
      case (paddr)
        OFS_CTRL: begin
          st_d.c.prdata[CTRL_GO_BIT] = st_q.c.go;
          st_d.c.prdata[CTRL_ON_BIT] = st_q.c.on;
          st_d.c.prdata[CTRL_CH_LSB +: 4] = st_q.c.chan;
        end
        OFS_PINCFG: begin
          st_d.c.prdata[7:0] = st_q.c.pincfg;
        end
        OFS_ACQCLK: begin
          st_d.c.prdata[CLK_SEL_LSB +: 3] = st_q.c.clk_sel;
          st_d.c.prdata[ACQ_SEL_LSB +: 3] = st_q.c.acq_sel;
        end
        OFS_RES_LO: begin
          st_d.c.prdata[7:0] = st_q.result[7:0];
        end
        OFS_RES_HI: begin
          st_d.c.prdata[RES_W-9:0] = st_q.result[RES_W-1:8];
        end
        OFS_IRQ: begin
          st_d.c.prdata[IRQ_FLAG_BIT] = st_q.c.flag;
          st_d.c.prdata[IRQ_EN_BIT] = st_q.c.irq_en;
        end
        default: begin
          st_d.c.pslverr = 1'b1;
        end
      endcase
    end
    if (wr) begin
      case (paddr)
        OFS_CTRL: begin
          st_d.c.on = pwdata[CTRL_ON_BIT];
          st_d.c.chan = pwdata[CTRL_CH_LSB +: 4];
          // go cannot be set while the converter is off
          st_d.c.go = pwdata[CTRL_GO_BIT] && pwdata[CTRL_ON_BIT];
        end
        OFS_PINCFG: begin
          st_d.c.pincfg = pwdata[7:0];
        end
        OFS_ACQCLK: begin
          st_d.c.acq_sel = pwdata[ACQ_SEL_LSB +: 3];
          st_d.c.clk_sel = pwdata[CLK_SEL_LSB +: 3];
        end
        OFS_RES_LO: begin
          st_d.result[7:0] = pwdata[7:0];
        end
        OFS_RES_HI: begin
          st_d.result[RES_W-1:8] = pwdata[RES_W-9:0];
        end
        OFS_IRQ: begin
          st_d.c.flag = pwdata[IRQ_FLAG_BIT];
          st_d.c.irq_en = pwdata[IRQ_EN_BIT];
        end
        default: begin
          st_d.c.on = st_q.c.on;
        end
      endcase
    end
    if (st_d.c.done) begin
      st_d.c.flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.c <= '0;
      st_q.c.acq_sel <= ACQ_SEL_RST;
      st_q.c.clk_sel <= CLK_SEL_RST;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign sample_connect  = st_q.c.on &&
                           (st_q.c.fsm == ST_IDLE || st_q.c.fsm == ST_ACQ);
  assign array_discharge = (st_q.c.fsm == ST_WAIT);
  assign chan_sel        = st_q.c.chan;
  assign dac_code        = st_q.c.sar;
  assign pin_cfg         = st_q.c.pincfg;
  assign prdata          = st_q.c.prdata;
  assign pslverr         = st_q.c.pslverr;
  assign pready          = 1'b1;
  assign conv_irq_req    = st_q.c.flag && st_q.c.irq_en;

  // tick counters seen only by the checks below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acq_ticks_q <= '0;
      conv_ticks_q <= '0;
    end else if (ce) begin
      acq_ticks_q <= (st_q.c.fsm == ST_ACQ) ?
                     acq_ticks_q + {4'h0, tad.tick} : 5'h00;
      conv_ticks_q <= (st_q.c.fsm == ST_CONV) ?
                      conv_ticks_q + {4'h0, tad.tick} : 5'h00;
    end
  end

  acq_reset_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (st_q.c.acq_sel == ACQ_SEL_RST))
    else $error("acquisition selector not manual after reset");

  manual_start_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && st_q.c.fsm == ST_IDLE && st_q.c.go && st_q.c.on &&
     st_q.c.acq_sel == ACQ_MANUAL)
      |=> (st_q.c.fsm == ST_CONV && !sample_connect))
    else $error("manual go did not start conversion at once");

  acq_sampling_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_q.c.fsm == ST_ACQ) |-> sample_connect)
    else $error("sampling stopped during acquisition");

  acq_length_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ($past(st_q.c.fsm) == ST_ACQ && st_q.c.fsm == ST_CONV &&
     $stable(st_q.c.acq_sel))
      |-> (acq_ticks_q == acs_acq_tads(st_q.c.acq_sel)))
    else $error("acquisition length differs from selector");

  conv_open_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_q.c.fsm == ST_CONV) |-> (!sample_connect && !array_discharge))
    else $error("capacitor connected during conversion");

  conv_length_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_q.c.done |-> (conv_ticks_q == 5'(CONV_TADS)))
    else $error("conversion did not last thirteen periods");

  done_effects_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_q.c.done |-> (st_q.c.flag && st_q.c.fsm == ST_WAIT &&
                     (!st_q.c.go || $past(ctrl_wr)) &&
                     st_q.result == st_q.c.sar))
    else $error("completion effects missing");

  abort_keep_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && st_q.c.fsm == ST_CONV && !st_q.c.go && !res_wr)
      |=> (st_q.result == $past(st_q.result) && st_q.c.fsm == ST_WAIT))
    else $error("abort changed the result");

  irq_follow_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_q.c.done |-> (conv_irq_req == st_q.c.irq_en))
    else $error("interrupt request does not follow completion");

endmodule
`default_nettype wire

// >>> verification/acs_analog_model.sv
// behavioural front end: sampling capacitor and comparator
`timescale 1ns/1ps
`default_nettype none
module acs_analog_model
  import acs_pkg::*;
(
  // clock
  input  wire logic             pclk,
  // control from the sequencer
  input  wire logic             sample_connect,
  input  wire logic             array_discharge,
  input  wire logic [3:0]       chan_sel,
  input  wire logic [RES_W-1:0] dac_code,
  // comparator
  output logic                  cmp_in
);
  logic [RES_W-1:0] held_q;
  // a distinct level per channel so a wrong mux shows
  wire logic [RES_W-1:0] level = {chan_sel, ~chan_sel, 4'h6};

  always @(posedge pclk) begin
    if (array_discharge)
      held_q <= '0;
    else if (sample_connect)
      held_q <= level;
  end

  assign cmp_in = (held_q >= dac_code);
endmodule
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import acs_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, cmp_in, ce;
  logic [7:0]  paddr, pin_cfg;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, sample_connect, array_discharge;
  logic        conv_irq_req;
  logic [3:0]  chan_sel;
  logic [11:0] dac_code;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  // clock codes in table order; rc source is 2.5 us at 8 ns
  localparam logic [2:0] CS_T [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2,
                                      3'h6, 3'h3};
  localparam int DV_T [7]  = '{2, 4, 8, 16, 32, 64, 312};
  localparam int ACQ_T [8] = '{0, 2, 4, 6, 8, 12, 16, 20};

  acs_sequencer dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_in(cmp_in), .sample_connect(sample_connect),
    .array_discharge(array_discharge), .chan_sel(chan_sel),
    .dac_code(dac_code), .pin_cfg(pin_cfg), .conv_irq_req(conv_irq_req)
  );

  acs_analog_model fe (
    .pclk(pclk), .sample_connect(sample_connect),
    .array_discharge(array_discharge), .chan_sel(chan_sel),
    .dac_code(dac_code), .cmp_in(cmp_in)
  );

  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end

  task automatic test_done();
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // longest path is the rc-clock conversion, well under this
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask

  // counts allow for the register and synchroniser stages
  task automatic chk_rng(string n, int e, int g);
    comparisons++;
    if (g < e - 1 || g > e + 2) begin
      fail_count++;
      $display("CHECK FAILED %s exp %0d got %0d", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'h1, a, d, r, e);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] x, logic xe, string n);
    logic [31:0] r;
    logic        e;
    apb(1'h0, a, 32'h0, r, e);
    chk(n, x, r);
    chk("pslverr", 32'(xe), 32'(e));
  endtask

  task automatic run(logic [3:0] ch, logic [2:0] acq, logic [2:0] cs,
                     int na, int dv);
    int          n;
    logic [11:0] v;
    v = {ch, ~ch, 4'h6};
    wr(OFS_ACQCLK, {26'h0, acq, cs});
    wr(OFS_CTRL, {26'h0, ch, 2'h2});
    repeat (8) @(posedge pclk); // settle before go
    wr(OFS_CTRL, {26'h0, ch, 2'h3});
    #1;
    n = 0;
    while (sample_connect === 1'h1) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk_rng("acq_cycles", na * dv, n);
    n = 0;
    while (sample_connect === 1'h0 && array_discharge === 1'h0) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk_rng("conv_cycles", 13 * dv, n);
    n = 0;
    while (array_discharge === 1'h1) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk_rng("wait_cycles", 2 * dv, n);
    chk("resample", 32'h1, 32'(sample_connect));
    rd(OFS_CTRL, {26'h0, ch, 2'h2}, 1'h0, "go_clear");
    rd(OFS_RES_LO, {24'h0, v[7:0]}, 1'h0, "res_lo");
    rd(OFS_RES_HI, {28'h0, v[11:8]}, 1'h0, "res_hi");
  endtask

  initial begin
    presetn = 1'h0;
    ce      = 1'h1;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 8'h0;
    pwdata  = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    rd(OFS_ACQCLK, 32'h0, 1'h0, "acqclk_rst");
    rd(OFS_IRQ, 32'h0, 1'h0, "irq_rst");
    rd(8'h18, 32'h0, 1'h1, "unmapped");
    wr(8'h1c, 32'hff);
    wr(OFS_PINCFG, 32'ha5);
    rd(OFS_PINCFG, 32'ha5, 1'h0, "pincfg");
    chk("pin_cfg", 32'ha5, 32'(pin_cfg));
    // a write while the enable is low must not land
    ce <= 1'h0;
    wr(OFS_PINCFG, 32'h3c);
    ce <= 1'h1;
    rd(OFS_PINCFG, 32'ha5, 1'h0, "ce_freeze");
    for (int i = 0; i < 7; i++) begin
      run(4'(i + 1), 3'h0, CS_T[i], 0, DV_T[i]);
    end
    // div 4 so one extra period is clearly visible
    for (int i = 1; i < 8; i++) begin
      run(4'(i), 3'(i), 3'h4, ACQ_T[i], 4);
    end
    wr(OFS_IRQ, 32'h2);
    #1 chk("irq_idle", 32'h0, 32'(conv_irq_req));
    run(4'h9, 3'h0, 3'h0, 0, 2);
    chk("irq_set", 32'h1, 32'(conv_irq_req));
    rd(OFS_IRQ, 32'h3, 1'h0, "irq_reg");
    wr(OFS_IRQ, 32'h1);
    #1 chk("irq_masked", 32'h0, 32'(conv_irq_req));
    wr(OFS_IRQ, 32'h0);
    // software-written result must survive an abort
    wr(OFS_RES_LO, 32'h5a);
    wr(OFS_RES_HI, 32'h3);
    wr(OFS_ACQCLK, {26'h0, 3'h7, 3'h4});
    wr(OFS_CTRL, 32'h2b);
    rd(OFS_CTRL, 32'h2b, 1'h0, "go_acq");
    repeat (85) @(posedge pclk);
    rd(OFS_CTRL, 32'h2b, 1'h0, "go_conv");
    #1 chk("in_conv", 32'h0, 32'(sample_connect));
    wr(OFS_CTRL, 32'h2a);
    repeat (12) @(posedge pclk);
    rd(OFS_RES_LO, 32'h5a, 1'h0, "abort_lo");
    rd(OFS_RES_HI, 32'h3, 1'h0, "abort_hi");
    rd(OFS_IRQ, 32'h0, 1'h0, "abort_flag");
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    rd(OFS_RES_LO, 32'h5a, 1'h0, "rst_lo");
    rd(OFS_RES_HI, 32'h3, 1'h0, "rst_hi");
    rd(OFS_ACQCLK, 32'h0, 1'h0, "acq_rst2");
    test_done();
  end
endmodule
`default_nettype wire
